// ==== rtl/sat_cfg.svh ====
`ifndef SAT_CFG_SVH
`define SAT_CFG_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define SAT_CA_W        10
`define SAT_DQ_W        8
`define SAT_ROW_W       13
`define SAT_COL_W       11
`define SAT_NBANK       8
`define SAT_DIV_W       2

// ----------------------------------------
// Link fields
// ----------------------------------------
`define SAT_F_CODE2     1:0
`define SAT_F_CODE4     3:0
`define SAT_F_RDWR      2
`define SAT_F_AB        4
`define SAT_F_BA        9:7
`define SAT_F_ROWR      6:2
`define SAT_F_ROWF      7:0
`define SAT_F_COLR      6:5
`define SAT_F_COLF      9:1
`define SAT_F_MAR       9:4
`define SAT_F_MAF       1:0
`define SAT_F_OPF       9:2
`define SAT_ROW_LO      4:0
`define SAT_ROW_HI      12:5
`define SAT_COL_LO      1:0
`define SAT_COL_HI      10:2
`define SAT_CODE_ACT    2'h2
`define SAT_CODE_COL    2'h1
`define SAT_CODE_PRE    4'hb
`define SAT_CODE_REF    4'h4
`define SAT_CODE_MRW    4'h0

// ----------------------------------------
// Mode register addresses
// ----------------------------------------
`define SAT_MA_RESET    8'h3f
`define SAT_MA_R1_LO    8'h12
`define SAT_MA_R1_HI    8'h1f
`define SAT_MA_R2_LO    8'h21
`define SAT_MA_R2_HI    8'h3e
`define SAT_MA_R3_LO    8'h40

// ----------------------------------------
// Timing
// ----------------------------------------
`define SAT_CORE_NS     100
`define SAT_CK_DIV      4
`define SAT_CK_HALF     2
`define SAT_RISE_PH     1
`define SAT_TCK_NS      (`SAT_CORE_NS * `SAT_CK_DIV)
`define SAT_RL          3
`define SAT_WL          1
`define SAT_BL          4
`define SAT_TRCD_CK     3
`define SAT_TRPPB_CK    3
`define SAT_TRPAB_CK    4
`define SAT_TRRD_CK     2
`define SAT_TRAS_CK     7
`define SAT_TRC_CK      10
`define SAT_T_FAW_NS    4000
`define SAT_T_DQSCK_NS  5
`define SAT_FAW_CK      ((`SAT_T_FAW_NS + `SAT_TCK_NS - 1) / `SAT_TCK_NS)
`define SAT_CCD_CK      (`SAT_BL / 2)
`define SAT_RTW_CK      (`SAT_RL + (`SAT_T_DQSCK_NS + `SAT_TCK_NS - 1) / `SAT_TCK_NS \
                         + `SAT_BL / 2 + 1 - `SAT_WL)

// ----------------------------------------
// Controller registers
// ----------------------------------------
`define SAT_REG_CTRL    8'h00
`define SAT_REG_ADDR    8'h04
`define SAT_REG_STAT    8'h08
`define SAT_REG_RDAT    8'h0c
`define SAT_F_OP        2:0
`define SAT_F_GO        3
`define SAT_F_MRD       15:8
`define SAT_F_MA        23:16
`define SAT_F_BANK      2:0
`define SAT_F_ROW       15:3
`define SAT_F_COL       26:16
`endif

// ==== rtl/sat_pkg.sv ====
`include "sat_cfg.svh"
package sat_pkg;
  typedef enum logic [2:0] {CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_REF, CMD_MRW,
                            CMD_OTHER} sat_cmd_t;
  typedef enum logic [2:0] {OP_RD, OP_WR, OP_PREA, OP_MRW, OP_REF} sat_op_t;
  typedef enum logic {ST_IDLE, ST_RUN} sat_st_t;

  typedef struct packed {
    logic                  v;
    logic [2:0]            bank;
    logic [`SAT_COL_W-1:0] col;
  } sat_slot_t;

  typedef struct packed {
    logic [1:0]                       ck_s;
    logic                             ck_d;
    logic [1:0]                       cs_s;
    logic [1:0][`SAT_CA_W-1:0]        ca_s;
    logic                             cs_r;
    logic [`SAT_CA_W-1:0]             ca_r;
    logic [`SAT_NBANK-1:0]            open;
    logic [`SAT_NBANK-1:0][3:0]       age;
    sat_slot_t [`SAT_RL-1:0]          pipe;
    logic                             bact;
    logic [4:0]                       beat;
    logic [2:0]                       bbank;
    logic [`SAT_COL_W-1:0]            bcol;
    logic [`SAT_DQ_W-1:0]             dq;
    logic                             dq_oe;
    logic                             dqs;
    logic                             dqs_oe;
    logic                             err;
    logic                             srst_p;
  } sat_dev_t;

  typedef struct packed {
    logic [`SAT_DIV_W-1:0]               div;
    logic                                ck_o;
    logic                                cs_n;
    logic [`SAT_CA_W-1:0]                ca;
    logic [`SAT_CA_W-1:0]                ca_f;
    logic [15:0]                         now;
    sat_st_t                             st;
    sat_op_t                             op;
    logic [7:0]                          ma;
    logic [7:0]                          mrd;
    logic [2:0]                          bank;
    logic [`SAT_ROW_W-1:0]               row;
    logic [`SAT_COL_W-1:0]               col;
    logic                                refused;
    logic [`SAT_NBANK-1:0]               open;
    logic [`SAT_NBANK-1:0][`SAT_ROW_W-1:0] rowt;
    logic [`SAT_NBANK-1:0][15:0]         t_act;
    logic [`SAT_NBANK-1:0][15:0]         t_col;
    logic [`SAT_NBANK-1:0][15:0]         t_pre;
    logic [15:0]                         t_rrd;
    logic [15:0]                         t_rd;
    logic [15:0]                         t_wr;
    logic [3:0][15:0]                    faw;
    logic [1:0][`SAT_DQ_W-1:0]           dq_s;
    logic [1:0]                          dqs_s;
    logic                                dqs_d;
    logic [31:0]                         rdata;
    logic                                pready;
    logic                                pslverr;
    logic [31:0]                         prdata;
  } sat_ctl_t;

  function automatic sat_cmd_t sat_decode(input logic [`SAT_CA_W-1:0] ca);
    if (ca[`SAT_F_CODE2] == `SAT_CODE_ACT)
      return CMD_ACT;
    if (ca[`SAT_F_CODE2] == `SAT_CODE_COL)
      return ca[`SAT_F_RDWR] ? CMD_RD : CMD_WR;
    if (ca[`SAT_F_CODE4] == `SAT_CODE_PRE)
      return CMD_PRE;
    if (ca[`SAT_F_CODE4] == `SAT_CODE_REF)
      return CMD_REF;
    if (ca[`SAT_F_CODE4] == `SAT_CODE_MRW)
      return CMD_MRW;
    return CMD_OTHER;
  endfunction

  function automatic logic sat_forbidden(input logic [7:0] ma);
    return (ma >= `SAT_MA_R1_LO && ma <= `SAT_MA_R1_HI) ||
           (ma >= `SAT_MA_R2_LO && ma <= `SAT_MA_R2_HI) || ma >= `SAT_MA_R3_LO;
  endfunction

  function automatic logic sat_due(input logic [15:0] now, input logic [15:0] t);
    logic [15:0] d;
    d = now - t;
    return ~d[15];
  endfunction

  function automatic logic [15:0] sat_later(input logic [15:0] a, input logic [15:0] b);
    logic [15:0] d;
    d = a - b;
    return d[15] ? b : a;
  endfunction
endpackage

// ==== rtl/sat_link_if.sv ====
`timescale 1ns/1ps
`include "sat_cfg.svh"
interface sat_link_if;
  logic                 ck;
  logic                 cs_n;
  logic [`SAT_CA_W-1:0] ca;
  logic [`SAT_DQ_W-1:0] dq_o;
  logic                 dq_oe;
  logic                 dqs_o;
  logic                 dqs_oe;
  logic [`SAT_DQ_W-1:0] dq;
  logic                 dqs;

  // Wire levels from the device enables
  assign dq  = dq_oe ? dq_o : '0;
  assign dqs = dqs_oe & dqs_o;

  modport dev (input ck, cs_n, ca, output dq_o, dq_oe, dqs_o, dqs_oe);
  modport ctl (output ck, cs_n, ca, input dq, dqs);
endinterface

// ==== rtl/sat_mem_dev.sv ====
`timescale 1ns/1ps
`include "sat_cfg.svh"
module sat_mem_dev (
  input  wire logic                  CORE_CLK,
  input  wire logic                  SRST,
  sat_link_if.dev                    LINK,
  output logic [`SAT_NBANK-1:0]      OPEN_BANKS,
  output logic                       ERR,
  output logic                       SOFT_RST
);
  sat_pkg::sat_dev_t r_reg;
  sat_pkg::sat_dev_t r_next;
  sat_pkg::sat_cmd_t cmd;
  logic              rise;
  logic              fall;
  logic [2:0]        b;
  logic [7:0]        ma;

  function automatic logic [`SAT_DQ_W-1:0] beat_data(input logic [2:0] bk,
                                                     input logic [`SAT_COL_W-1:0] c,
                                                     input logic [4:0] bt);
    return {bk, c[4:0]} + {3'h0, bt};
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    r_next = r_reg;
    cmd    = sat_pkg::CMD_NOP;
    b      = r_reg.ca_r[`SAT_F_BA];
    ma     = {r_reg.ca_r[`SAT_F_MAR], r_reg.ca_s[1][`SAT_F_MAF]};
    r_next.ck_s   = {r_reg.ck_s[0], LINK.ck};
    r_next.ck_d   = r_reg.ck_s[1];
    r_next.cs_s   = {r_reg.cs_s[0], LINK.cs_n};
    r_next.ca_s   = {r_reg.ca_s[0], LINK.ca};
    r_next.srst_p = 1'b0;
    rise = r_reg.ck_s[1] & ~r_reg.ck_d;
    fall = ~r_reg.ck_s[1] & r_reg.ck_d;
    if (rise)
    begin
      r_next.cs_r = r_reg.cs_s[1];
      r_next.ca_r = r_reg.ca_s[1];
      for (int i = 0; i < `SAT_NBANK; i++)
      begin
        if (r_reg.age[i] != 4'hf)
          r_next.age[i] = r_reg.age[i] + 4'h1;
      end
      r_next.pipe = {r_reg.pipe[`SAT_RL-2:0], sat_pkg::sat_slot_t'('0)};
    end
    // Burst output
    if (rise && r_reg.pipe[`SAT_RL-1].v)
    begin
      if (r_reg.bact && r_reg.beat != 5'(`SAT_BL - 1) &&
          (`SAT_BL == 4 || r_reg.beat[1:0] != 2'h3))
        r_next.err = 1'b1;
      r_next.bact   = 1'b1;
      r_next.beat   = 5'h0;
      r_next.bbank  = r_reg.pipe[`SAT_RL-1].bank;
      r_next.bcol   = r_reg.pipe[`SAT_RL-1].col;
      r_next.dqs    = 1'b1;
      r_next.dqs_oe = 1'b1;
      r_next.dq_oe  = 1'b1;
      r_next.dq     = beat_data(r_reg.pipe[`SAT_RL-1].bank, r_reg.pipe[`SAT_RL-1].col, 5'h0);
    end
    else if ((rise || fall) && r_reg.bact)
    begin
      if (r_reg.beat == 5'(`SAT_BL - 1))
      begin
        r_next.bact   = 1'b0;
        r_next.dq_oe  = 1'b0;
        r_next.dqs    = 1'b0;
        r_next.dqs_oe = 1'b0;
      end
      else
      begin
        r_next.beat = r_reg.beat + 5'h1;
        r_next.dqs  = ~r_reg.dqs;
        r_next.dq   = beat_data(r_reg.bbank, r_reg.bcol, r_reg.beat + 5'h1);
      end
    end
    if (rise && r_reg.pipe[`SAT_RL-2].v && !r_next.bact)
    begin
      r_next.dqs_oe = 1'b1;
      r_next.dqs    = 1'b0;
    end
    // Command decode on the falling half
    if (fall && !r_reg.cs_r)
    begin
      cmd = sat_pkg::sat_decode(r_reg.ca_r);
      unique case (cmd)
        sat_pkg::CMD_ACT:
        begin
          if (r_reg.open[b])
            r_next.err = 1'b1;
          r_next.open[b] = 1'b1;
          r_next.age[b]  = 4'h0;
        end
        sat_pkg::CMD_RD, sat_pkg::CMD_WR:
        begin
          if (!r_reg.open[b] || r_reg.age[b] < 4'(`SAT_TRCD_CK))
            r_next.err = 1'b1;
          if (cmd == sat_pkg::CMD_RD)
          begin
            r_next.pipe[0].v    = 1'b1;
            r_next.pipe[0].bank = b;
            r_next.pipe[0].col  = {r_reg.ca_s[1][`SAT_F_COLF], r_reg.ca_r[`SAT_F_COLR]};
          end
        end
        sat_pkg::CMD_PRE:
        begin
          if (r_reg.ca_r[`SAT_F_AB])
            r_next.open = '0;
          else
            r_next.open[b] = 1'b0;
        end
        sat_pkg::CMD_MRW:
        begin
          if (ma == `SAT_MA_RESET)
          begin
            r_next.open   = '0;
            r_next.pipe   = '0;
            r_next.bact   = 1'b0;
            r_next.dq_oe  = 1'b0;
            r_next.dqs    = 1'b0;
            r_next.dqs_oe = 1'b0;
            r_next.srst_p = 1'b1;
          end
          else if (sat_pkg::sat_forbidden(ma))
            r_next.err = 1'b1;
        end
        sat_pkg::CMD_NOP, sat_pkg::CMD_REF, sat_pkg::CMD_OTHER:
        begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
      r_reg <= '0;
    else
      r_reg <= r_next;
  end

  assign OPEN_BANKS  = r_reg.open;
  assign ERR         = r_reg.err;
  assign SOFT_RST    = r_reg.srst_p;
  assign LINK.dq_o   = r_reg.dq;
  assign LINK.dq_oe  = r_reg.dq_oe;
  assign LINK.dqs_o  = r_reg.dqs;
  assign LINK.dqs_oe = r_reg.dqs_oe;
endmodule

// ==== rtl/sat_ctrl.sv ====
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`include "sat_cfg.svh"
module sat_ctrl (
  input  wire logic        CORE_CLK,
  input  wire logic        SRST,
  sat_link_if.ctl          LINK,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR
);
  sat_pkg::sat_ctl_t r_reg;
  sat_pkg::sat_ctl_t r_next;
  sat_pkg::sat_op_t  op_w;
  logic [15:0]       tn;
  logic [2:0]        b;
  logic              tick;
  logic              acc;
  logic              ok_act;
  logic              pa_ok;
  logic              do_act;
  logic              do_ref;
  logic              do_pre;
  logic              do_prea;
  logic              do_col;
  logic              do_mrw;

  always_comb
  begin
    r_next  = r_reg;
    tn      = r_reg.now + 16'h1;
    b       = r_reg.bank;
    op_w    = sat_pkg::sat_op_t'(PWDATA[`SAT_F_OP]);
    do_act  = 1'b0;
    do_ref  = 1'b0;
    do_pre  = 1'b0;
    do_prea = 1'b0;
    do_col  = 1'b0;
    do_mrw  = 1'b0;
    pa_ok   = 1'b1;
    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    acc            = PSEL & PENABLE & r_reg.pready;
    r_next.pready  = PSEL & PENABLE & ~r_reg.pready;
    r_next.pslverr = 1'b0;
    r_next.prdata  = '0;
    if (PSEL & PENABLE & ~r_reg.pready)
    begin
      case (PADDR)
        `SAT_REG_CTRL: r_next.prdata = {8'h0, r_reg.ma, r_reg.mrd, 5'h0, r_reg.op};
        `SAT_REG_ADDR: r_next.prdata = {5'h0, r_reg.col, r_reg.row, r_reg.bank};
        `SAT_REG_STAT: r_next.prdata = {30'h0, r_reg.refused, r_reg.st == sat_pkg::ST_RUN};
        `SAT_REG_RDAT: r_next.prdata = r_reg.rdata;
        default:       r_next.pslverr = 1'b1;
      endcase
    end
    if (acc && PWRITE && r_reg.st == sat_pkg::ST_IDLE)
    begin
      if (PADDR == `SAT_REG_ADDR)
      begin
        r_next.bank = PWDATA[`SAT_F_BANK];
        r_next.row  = PWDATA[`SAT_F_ROW];
        r_next.col  = PWDATA[`SAT_F_COL];
      end
      if (PADDR == `SAT_REG_CTRL && PWDATA[`SAT_F_GO])
      begin
        r_next.op      = op_w;
        r_next.ma      = PWDATA[`SAT_F_MA];
        r_next.mrd     = PWDATA[`SAT_F_MRD];
        r_next.refused = op_w > sat_pkg::OP_REF ||
                         (op_w == sat_pkg::OP_MRW && sat_pkg::sat_forbidden(PWDATA[`SAT_F_MA]));
        if (!r_next.refused)
          r_next.st = sat_pkg::ST_RUN;
      end
    end
    else if (acc && PWRITE && PADDR == `SAT_REG_CTRL && PWDATA[`SAT_F_GO])
      r_next.refused = 1'b1;
    // ----------------------------------------
    // Link clock divider
    // ----------------------------------------
    tick        = r_reg.div == `SAT_DIV_W'(`SAT_CK_DIV - 1);
    r_next.div  = tick ? '0 : r_reg.div + `SAT_DIV_W'(1);
    r_next.ck_o = r_next.div != '0 && r_next.div <= `SAT_DIV_W'(`SAT_CK_HALF);
    if (r_reg.div == `SAT_DIV_W'(`SAT_RISE_PH))
      r_next.ca = r_reg.ca_f;
    // ----------------------------------------
    // Command scheduling, one per link clock
    // ----------------------------------------
    ok_act = sat_pkg::sat_due(tn, r_reg.t_act[b]) && sat_pkg::sat_due(tn, r_reg.t_rrd) &&
             sat_pkg::sat_due(tn, r_reg.faw[3] + 16'(`SAT_FAW_CK));
    for (int i = 0; i < `SAT_NBANK; i++)
    begin
      if (r_reg.open[i] && !sat_pkg::sat_due(tn, r_reg.t_pre[i]))
        pa_ok = 1'b0;
    end
    if (tick)
    begin
      r_next.now  = tn;
      r_next.cs_n = 1'b1;
      r_next.ca   = '0;
      r_next.ca_f = '0;
      if (r_reg.st == sat_pkg::ST_RUN)
      begin
        unique case (r_reg.op)
          sat_pkg::OP_RD, sat_pkg::OP_WR:
          begin
            if (r_reg.open[b] && r_reg.rowt[b] == r_reg.row)
              do_col = sat_pkg::sat_due(tn, r_reg.t_col[b]) &&
                       sat_pkg::sat_due(tn, r_reg.op == sat_pkg::OP_RD ? r_reg.t_rd : r_reg.t_wr);
            else if (r_reg.open[b])
              do_pre = sat_pkg::sat_due(tn, r_reg.t_pre[b]);
            else
              do_act = ok_act;
          end
          sat_pkg::OP_REF:
          begin
            if (r_reg.open[b])
              do_pre = sat_pkg::sat_due(tn, r_reg.t_pre[b]);
            else
              do_ref = ok_act;
          end
          sat_pkg::OP_PREA: do_prea = pa_ok;
          sat_pkg::OP_MRW:  do_mrw = 1'b1;
        endcase
      end
      if (do_act || do_ref)
      begin
        r_next.cs_n                = 1'b0;
        r_next.ca[`SAT_F_BA]       = b;
        r_next.t_rrd               = tn + 16'(`SAT_TRRD_CK);
        r_next.t_act[b]            = tn + 16'(`SAT_TRC_CK);
        r_next.faw                 = {r_reg.faw[2:0], tn};
        if (do_ref)
        begin
          r_next.ca[`SAT_F_CODE4] = `SAT_CODE_REF;
          r_next.st               = sat_pkg::ST_IDLE;
        end
        else
        begin
          r_next.ca[`SAT_F_CODE2]  = `SAT_CODE_ACT;
          r_next.ca[`SAT_F_ROWR]   = r_reg.row[`SAT_ROW_LO];
          r_next.ca_f[`SAT_F_ROWF] = r_reg.row[`SAT_ROW_HI];
          r_next.open[b]           = 1'b1;
          r_next.rowt[b]           = r_reg.row;
          r_next.t_col[b]          = tn + 16'(`SAT_TRCD_CK);
          r_next.t_pre[b]          = tn + 16'(`SAT_TRAS_CK);
        end
      end
      if (do_pre || do_prea)
      begin
        r_next.cs_n             = 1'b0;
        r_next.ca[`SAT_F_CODE4] = `SAT_CODE_PRE;
        r_next.ca[`SAT_F_BA]    = b;
        r_next.ca[`SAT_F_AB]    = do_prea;
        if (do_prea)
        begin
          r_next.open = '0;
          r_next.st   = sat_pkg::ST_IDLE;
          for (int i = 0; i < `SAT_NBANK; i++)
            r_next.t_act[i] = sat_pkg::sat_later(r_reg.t_act[i], tn + 16'(`SAT_TRPAB_CK));
        end
        else
        begin
          r_next.open[b]  = 1'b0;
          r_next.t_act[b] = sat_pkg::sat_later(r_reg.t_act[b], tn + 16'(`SAT_TRPPB_CK));
        end
      end
      if (do_col)
      begin
        r_next.cs_n                = 1'b0;
        r_next.ca[`SAT_F_CODE2]    = `SAT_CODE_COL;
        r_next.ca[`SAT_F_RDWR]     = r_reg.op == sat_pkg::OP_RD;
        r_next.ca[`SAT_F_BA]       = b;
        r_next.ca[`SAT_F_COLR]     = r_reg.col[`SAT_COL_LO];
        r_next.ca_f[`SAT_F_COLF]   = r_reg.col[`SAT_COL_HI];
        r_next.t_rd                = tn + 16'(`SAT_CCD_CK);
        r_next.t_wr                = tn + 16'(`SAT_CCD_CK);
        if (r_reg.op == sat_pkg::OP_RD)
          r_next.t_wr = tn + 16'(`SAT_RTW_CK);
        r_next.st = sat_pkg::ST_IDLE;
      end
      if (do_mrw)
      begin
        r_next.cs_n               = 1'b0;
        r_next.ca[`SAT_F_CODE4]   = `SAT_CODE_MRW;
        r_next.ca[`SAT_F_MAR]     = r_reg.ma[7:2];
        r_next.ca_f[`SAT_F_MAF]   = r_reg.ma[1:0];
        r_next.ca_f[`SAT_F_OPF]   = r_reg.mrd;
        r_next.st                 = sat_pkg::ST_IDLE;
        if (r_reg.ma == `SAT_MA_RESET)
          r_next.open = '0;
      end
    end
    // ----------------------------------------
    // Read data capture on strobe edges
    // ----------------------------------------
    r_next.dq_s  = {r_reg.dq_s[0], LINK.dq};
    r_next.dqs_s = {r_reg.dqs_s[0], LINK.dqs};
    r_next.dqs_d = r_reg.dqs_s[1];
    if (r_reg.dqs_s[1] != r_reg.dqs_d)
      r_next.rdata = {r_reg.rdata[23:0], r_reg.dq_s[1]};
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
      r_reg <= '0;
    else
      r_reg <= r_next;
  end

  assign LINK.ck   = r_reg.ck_o;
  assign LINK.cs_n = r_reg.cs_n;
  assign LINK.ca   = r_reg.ca;
  assign PRDATA    = r_reg.prdata;
  assign PREADY    = r_reg.pready;
  assign PSLVERR   = r_reg.pslverr;
endmodule

// ==== test/sat_link_assertions.sv ====
`timescale 1ns/1ps
`include "sat_cfg.svh"
module sat_link_assertions (
  input wire logic                 CORE_CLK,
  input wire logic                 SRST,
  input wire logic                 ck,
  input wire logic                 cs_n,
  input wire logic [`SAT_CA_W-1:0] ca,
  input wire logic                 dq_oe,
  input wire logic                 dqs_o,
  input wire logic                 dqs_oe
);
  // ----------------------------------------
  // Link checks
  // ----------------------------------------
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (SRST);

  sequence rd_cmd;
    $rose(ck) && !cs_n && ca[1:0] == 2'h1 && ca[2];
  endsequence

  a_ck_divide: assert property ($rose(ck) |-> ck[*2] ##1 !ck[*2] ##1 ck)
    else $error("link clock period wrong");
  a_cmd_held: assert property ($fell(cs_n) |-> !cs_n[*4])
    else $error("command not held one link clock");
  a_read_latency: assert property (rd_cmd |-> ##[12:18] dq_oe)
    else $error("read data late");
  a_preamble_low: assert property ($rose(dqs_oe) |-> !dqs_o)
    else $error("strobe not low in preamble");
  a_preamble_first: assert property ($rose(dq_oe) |-> $past(dqs_oe))
    else $error("data without preamble");
  a_first_rise: assert property ($rose(dq_oe) |-> dqs_o[*2] ##1 !dqs_o)
    else $error("first beat not on rising strobe");
  a_data_strobe: assert property (!dqs_oe |-> !dq_oe)
    else $error("data driven without strobe");
  a_burst_len: assert property ($rose(dq_oe) |-> dq_oe[*8])
    else $error("burst shorter than four beats");
  c_read: cover property (rd_cmd);
  c_burst: cover property ($rose(dq_oe));
  c_cmd: cover property ($fell(cs_n));
endmodule

// ==== test/tb_sdram_activate_read_timing.sv ====
`timescale 1ns/1ps
`include "sat_cfg.svh"
`define CHK(n, x, g) begin compares++; if ((g) !== (x)) begin bad_count++; \
  $display("Error %s expected %h seen %h", n, x, g); end end
module tb_sdram_activate_read_timing;
  logic                  clk = 1'b0;
  logic                  srst = 1'b1;
  logic                  psel = 1'b0;
  logic                  penable = 1'b0;
  logic                  pwrite = 1'b0;
  logic [7:0]            paddr = 8'h00;
  logic [31:0]           pwdata = 32'h0;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  logic [`SAT_NBANK-1:0] open_banks;
  logic                  err;
  logic                  soft_rst;
  logic                  soft_seen = 1'b0;
  logic [31:0]           q;
  logic                  e;
  logic [2:0]            banks [3] = '{3'h3, 3'h5, 3'h5};
  logic [10:0]           cols [3] = '{11'h1a4, 11'h013, 11'h01f};
  logic [7:0]            rsv [6] = '{8'h12, 8'h21, 8'h40, 8'h7f, 8'hbf, 8'hff};
  int                    bad_count = 0;
  int                    compares = 0;

  sat_link_if link ();
  always #50 clk = ~clk;
  always @(posedge clk) if (soft_rst === 1'b1) soft_seen <= 1'b1;

  sat_mem_dev u_sat_mem_dev (.CORE_CLK(clk), .SRST(srst), .LINK(link),
    .OPEN_BANKS(open_banks), .ERR(err), .SOFT_RST(soft_rst));
  sat_ctrl u_sat_ctrl (.CORE_CLK(clk), .SRST(srst), .LINK(link), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
  sat_link_assertions u_sat_link_assertions (.CORE_CLK(clk), .SRST(srst), .ck(link.ck),
    .cs_n(link.cs_n), .ca(link.ca), .dq_oe(link.dq_oe), .dqs_o(link.dqs_o),
    .dqs_oe(link.dqs_oe));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic go(input logic [2:0] op, input logic [7:0] ma, input logic [31:0] ad);
    apb(1'b1, `SAT_REG_ADDR, ad);
    apb(1'b1, `SAT_REG_CTRL, {8'h00, ma, 8'h5a, 4'h0, 1'b1, op});
    do
      apb(1'b0, `SAT_REG_STAT, 32'h0);
    while (q[0] !== 1'b0);
    repeat (40) @(posedge clk);
  endtask

  function automatic logic [31:0] rd_exp(input logic [2:0] b, input logic [10:0] c);
    logic [7:0] s;
    s = {b, c[4:0]};
    return {s, s + 8'h1, s + 8'h2, s + 8'h3};
  endfunction

  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      go(3'h0, 8'h00, {5'h0, cols[i], 13'h0005, banks[i]});
      `CHK("refused", 1'b0, q[1])
      `CHK("open", 1'b1, open_banks[banks[i]])
      apb(1'b0, `SAT_REG_RDAT, 32'h0);
      `CHK("rdat", rd_exp(banks[i], cols[i]), q)
    end
    $display("test reads done");
    go(3'h4, 8'h00, 32'h1);
    `CHK("refresh", 1'b0, q[1])
    go(3'h2, 8'h00, 32'h0);
    `CHK("open all", 8'h00, open_banks)
    go(3'h0, 8'h00, {5'h0, 11'h008, 13'h0, 3'h3});
    apb(1'b0, `SAT_REG_RDAT, 32'h0);
    `CHK("reopen", rd_exp(3'h3, 11'h008), q)
    go(3'h1, 8'h00, {5'h0, 11'h008, 13'h0, 3'h3});
    `CHK("write", 1'b0, q[1])
    go(3'h0, 8'h00, {5'h0, 11'h002, 13'h0001, 3'h3});
    `CHK("row change", 1'b0, q[1])
    apb(1'b0, `SAT_REG_RDAT, 32'h0);
    `CHK("new row", rd_exp(3'h3, 11'h002), q)
    $display("test precharge done");
    go(3'h3, 8'h3f, 32'h0);
    `CHK("soft reset", 1'b1, soft_seen)
    foreach (rsv[i])
    begin
      go(3'h3, rsv[i], 32'h0);
      `CHK("reserved", 1'b1, q[1])
    end
    apb(1'b0, 8'h10, 32'h0);
    `CHK("unmapped", 1'b1, e)
    `CHK("err", 1'b0, err)
    $display("test modes done");
    close_out();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    close_out();
  end
endmodule
